/* core/remote_param_port.sv */
`timescale 1ns/10ps
`include "remote_port_consts.svh"
// What this block does
// R1 - Attention low marks bytes as address words; high marks parameter data words.
// R2 - Controller drives remote enable and interface clear, both active low.
// R3 - Receiver raises service request when it needs controller attention.
// R4 - Transmitting party marks the final byte of a sequence with end-or-identify.
// R5 - Whole receiver state is 64 bits held in eight 8-bit registers.
// R6 - Command mode: receiver address first, then register address before each data word.
// R7 - Monitor mode sends address header then every data byte in ascending order.
// R8 - Header holds address in low five bits, bits 7 and 6 set.
// R9 - Data words never have both top bits set, staying below 192.
// R10 - Monitor resumes at the slot where the previous monitor transfer stopped.
// R11 - Register 1 holds remote flag, oscillator sign, gain mode, tens-of-MHz low bits.
// R12 - Gain codes fast 128, manual 132, slow 136; negative sign adds bit 4.
// R13 - Register 1 value 10000101 means remote, manual gain, tens digit 1.
// R14 - Register 1 bit 7 shows remote; bus writes cannot change it.
// R15 - Registers 2, 3, 4 hold packed BCD frequency digit pairs.
// R16 - More significant BCD digit sits in the upper nibble.
// R17 - Register 5 holds bandwidth in upper three bits, detection in lower five.
// R18 - Detection and bandwidth codes follow the fixed code table.
// R19 - Register 7 takes RF gain as an unsigned byte, 0 to 255.
// R20 - Oscillator sign is ignored when the detection mode is AM.
// R21 - Controller may write pairs in any order and omit unchanged registers.
// R22 - Controller addresses receivers with a binary address from 0 to 30.
// R23 - Unwritten registers keep contents; a write lands after its handshake completes.
module remote_param_port (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Address strap and front panel
    input wire logic [4:0] busAddress,
    input wire logic remoteButton,
    // Data lines, negative logic
    input wire remote_port_pkg::byte_type dioInN,
    output remote_port_pkg::byte_type dioOutN,
    output logic dioOe,
    // Handshake lines
    input wire logic davInN,
    output logic davOutN,
    output logic davOe,
    input wire logic nrfdInN,
    output logic nrfdOutN,
    output logic nrfdOe,
    input wire logic ndacInN,
    output logic ndacOutN,
    output logic ndacOe,
    // Management lines
    input wire logic atnN,
    input wire logic renN,
    input wire logic ifcN,
    input wire logic eoiInN,
    output logic eoiOutN,
    output logic eoiOe,
    output logic srqOutN,
    output logic srqOe,
    // Receiver controls
    output logic remoteFlag,
    output logic beatOscSign,
    output logic [1:0] gainMode,
    output logic [1:0] freqTens,
    output logic [23:0] freqDigits,
    output logic [2:0] bandwidthCode,
    output logic [4:0] detectionMode,
    output logic [7:0] rfGain,
    output logic paramUpdate
);
    import remote_port_pkg::*;

    localparam logic [`RP_PIN_W-1:0] PIN_IDLE = `RP_PIN_IDLE;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [`RP_PIN_W-1:0] pinRaw, pinClean;

    assign pinRaw = {remoteButton, eoiInN, ifcN, renN, atnN, ndacInN, nrfdInN, davInN, dioInN};

    // A change is taken only once the last two stages agree
    generate
        for (genvar i = 0; i < `RP_PIN_W; i++) begin : g_sync
            logic stage1, stage2, stage3, held, next_held;
            always_comb begin
                next_held = (stage2 == stage3) ? stage3 : held;
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    stage1 <= PIN_IDLE[i];
                    stage2 <= PIN_IDLE[i];
                    stage3 <= PIN_IDLE[i];
                    held <= PIN_IDLE[i];
                end else if (clkEn) begin
                    stage1 <= pinRaw[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    held <= next_held;
                end
            end
            assign pinClean[i] = held;
        end
    endgenerate

    byte_type busByte;
    logic davAct, nrfdHigh, ndacHigh, atnAct, renAct, ifcAct, eoiAct, remoteSel;

    assign busByte = ~pinClean[7:0];
    assign davAct = ~pinClean[`RP_PIN_DAV];
    assign nrfdHigh = pinClean[`RP_PIN_NRFD];
    assign ndacHigh = pinClean[`RP_PIN_NDAC];
    assign atnAct = ~pinClean[`RP_PIN_ATN];
    assign renAct = ~pinClean[`RP_PIN_REN];
    assign ifcAct = ~pinClean[`RP_PIN_IFC];
    assign eoiAct = ~pinClean[`RP_PIN_EOI];
    assign remoteSel = pinClean[`RP_PIN_REMOTE];

    // Address strap is caught while reset is held
    logic [4:0] myAddr;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            myAddr <= busAddress;
        end
    end

    // ----------------------------------------
    // Byte acceptor and buffer
    // ----------------------------------------
    word_stream_if toBuf ();
    word_stream_if fromBuf ();

    word_buffer #(.DEPTH(`RP_BUF_DEPTH)) u_buffer (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .fill(toBuf.sink),
        .drain(fromBuf.source)
    );

    accept_state_type acState, next_acState;
    logic listenAddr, next_listenAddr, talkAddr, next_talkAddr;
    logic participating, next_nrfdOe, next_ndacOe;

    // Address bytes are always taken; data bytes only while listening
    assign participating = atnAct || (listenAddr && !talkAddr);

    always_comb begin
        next_acState = acState;
        toBuf.valid = 1'b0;
        toBuf.word = '{eoi: eoiAct, cmd: atnAct, value: busByte}; // see R1
        unique case (acState)
            AC_IDLE: begin
                if (participating) begin
                    next_acState = AC_READY;
                end
            end
            AC_READY: begin
                if (!participating) begin
                    next_acState = AC_IDLE;
                end else if (davAct) begin
                    toBuf.valid = 1'b1;
                    if (toBuf.ready) begin
                        next_acState = AC_TAKEN;
                    end
                end
            end
            AC_TAKEN: begin
                if (!davAct) begin
                    next_acState = AC_READY;
                end
            end
            default: begin
                next_acState = AC_IDLE;
            end
        endcase
        if (ifcAct) begin
            next_acState = AC_IDLE;
        end
        // Holding not-ready while the buffer is full is what stalls the controller
        next_nrfdOe = (next_acState == AC_TAKEN) || (next_acState == AC_READY && !toBuf.ready);
        next_ndacOe = (next_acState == AC_READY);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acState <= AC_IDLE;
            nrfdOe <= 1'b0;
            ndacOe <= 1'b0;
            nrfdOutN <= 1'b0;
            ndacOutN <= 1'b0;
        end else if (clkEn) begin
            acState <= next_acState;
            nrfdOe <= next_nrfdOe;
            ndacOe <= next_ndacOe;
        end
    end

    // ----------------------------------------
    // Command interpreter and parameter registers
    // ----------------------------------------
    parse_state_type psState, next_psState;
    logic [2:0] regSel, next_regSel;
    byte_type dataHold, next_dataHold;
    byte_type regFile [`RP_NUM_REGS];
    byte_type next_regFile [`RP_NUM_REGS];
    byte_type cmdByte;
    logic next_paramUpdate;

    assign fromBuf.ready = (psState != PS_APPLY);
    assign cmdByte = fromBuf.word.value;

    always_comb begin
        next_psState = psState;
        next_regSel = regSel;
        next_dataHold = dataHold;
        next_regFile = regFile; // see R21, R23
        next_listenAddr = listenAddr;
        next_talkAddr = talkAddr;
        next_paramUpdate = 1'b0;
        if (fromBuf.valid && fromBuf.ready) begin
            if (fromBuf.word.cmd) begin
                next_psState = PS_ADDR;
                if (cmdByte == `RP_UNLISTEN) begin
                    next_listenAddr = 1'b0;
                end else if (cmdByte == `RP_UNTALK) begin
                    next_talkAddr = 1'b0;
                end else if (cmdByte[7:5] == `RP_LISTEN_GRP && cmdByte[4:0] == myAddr) begin
                    next_listenAddr = 1'b1;
                end else if (cmdByte[7:5] == `RP_TALK_GRP) begin
                    // Another unit's talk address silences this one
                    next_talkAddr = (cmdByte[4:0] == myAddr);
                end
            end else if (psState == PS_ADDR) begin
                // A register address marked as final has no data and is dropped
                if (!fromBuf.word.eoi) begin
                    next_regSel = cmdByte[2:0]; // see R6
                    next_psState = PS_DATA;
                end
            end else begin
                next_dataHold = cmdByte; // see R19
                next_psState = PS_APPLY;
            end
        end
        // Write waits for the controller to drop data valid
        if (psState == PS_APPLY && acState != AC_TAKEN) begin
            next_psState = PS_ADDR;
            if (renAct) begin
                next_regFile[regSel] = dataHold; // see R5, R23
                next_paramUpdate = 1'b1;
            end
        end
        next_regFile[`RP_REG_MODE][`RP_REMOTE_BIT] = remoteSel; // see R14
        if (ifcAct) begin
            next_listenAddr = 1'b0;
            next_talkAddr = 1'b0;
            next_psState = PS_ADDR;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            psState <= PS_ADDR;
            regSel <= '0;
            dataHold <= `RP_REG_RESET;
            listenAddr <= 1'b0;
            talkAddr <= 1'b0;
            paramUpdate <= 1'b0;
            for (int k = 0; k < `RP_NUM_REGS; k++) begin
                regFile[k] <= `RP_REG_RESET;
            end
        end else if (clkEn) begin
            psState <= next_psState;
            regSel <= next_regSel;
            dataHold <= next_dataHold;
            listenAddr <= next_listenAddr;
            talkAddr <= next_talkAddr;
            paramUpdate <= next_paramUpdate;
            regFile <= next_regFile;
        end
    end

    // ----------------------------------------
    // Decoded receiver controls
    // ----------------------------------------
    byte_type modeReg, bwReg;
    logic next_beatOscSign;

    assign modeReg = next_regFile[`RP_REG_MODE];
    assign bwReg = next_regFile[`RP_REG_BW_DET];

    always_comb begin
        // Oscillator sign has no meaning in AM and is forced positive there
        next_beatOscSign = modeReg[`RP_SIGN_BIT] && (bwReg[`RP_DET_HI:0] != `RP_DET_AM); // see R20
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remoteFlag <= 1'b0;
            beatOscSign <= 1'b0;
            gainMode <= '0;
            freqTens <= '0;
            freqDigits <= '0;
            bandwidthCode <= '0;
            detectionMode <= '0;
            rfGain <= '0;
        end else if (clkEn) begin
            remoteFlag <= modeReg[`RP_REMOTE_BIT]; // see R11, R13
            beatOscSign <= next_beatOscSign; // see R12
            gainMode <= modeReg[`RP_GAIN_HI:`RP_GAIN_LO]; // see R12
            freqTens <= modeReg[`RP_TENS_HI:0];
            freqDigits <= {next_regFile[`RP_REG_FREQ_HI], next_regFile[`RP_REG_FREQ_MID],
                           next_regFile[`RP_REG_FREQ_LO]}; // see R15, R16
            bandwidthCode <= bwReg[`RP_BW_HI:`RP_BW_LO]; // see R17, R18
            detectionMode <= bwReg[`RP_DET_HI:0];
            rfGain <= next_regFile[`RP_REG_RF_GAIN];
        end
    end

    // ----------------------------------------
    // Monitor talker and service request
    // ----------------------------------------
    talk_state_type tkState, next_tkState;
    logic [3:0] monPtr, next_monPtr;
    byte_type next_dioOutN, monByte;
    logic next_dioOe, next_davOe, next_eoiOe;
    logic talkActive, remotePrev, srqPend, next_srqPend;

    assign talkActive = talkAddr && !atnAct && !ifcAct;

    // Clearing bit 6 keeps any data word apart from the header
    function automatic byte_type guardData(input byte_type v);
        byte_type g;
        g = v;
        if (v[7:6] == `RP_HDR_MARK) begin
            g[`RP_HDR_GUARD_BIT] = 1'b0;
        end
        return g;
    endfunction : guardData

    always_comb begin
        if (monPtr == `RP_HDR_SLOT) begin
            monByte = {`RP_HDR_MARK, 1'b0, myAddr}; // see R8
        end else begin
            monByte = guardData(regFile[3'(monPtr - `RP_SLOT_STEP)]); // see R9
        end
        next_tkState = tkState;
        next_monPtr = monPtr;
        next_dioOutN = dioOutN;
        next_dioOe = dioOe;
        next_davOe = davOe;
        next_eoiOe = eoiOe;
        next_srqPend = srqPend;
        unique case (tkState)
            TK_IDLE: begin
                if (talkActive) begin
                    next_dioOutN = ~monByte; // see R7
                    next_dioOe = 1'b1;
                    next_eoiOe = (monPtr == `RP_LAST_SLOT); // see R4
                    next_tkState = TK_SETUP;
                end
            end
            TK_SETUP: begin
                if (nrfdHigh) begin
                    next_davOe = 1'b1;
                    next_tkState = TK_VALID;
                end
            end
            TK_VALID: begin
                if (ndacHigh) begin
                    next_davOe = 1'b0;
                    next_monPtr = (monPtr == `RP_LAST_SLOT) ? `RP_HDR_SLOT : 4'(monPtr + `RP_SLOT_STEP); // see R7
                    next_tkState = TK_RELEASE;
                    if (monPtr == `RP_HDR_SLOT) begin
                        next_srqPend = 1'b0;
                    end
                end
            end
            TK_RELEASE: begin
                next_dioOe = 1'b0;
                next_eoiOe = 1'b0;
                if (!ndacHigh || !talkActive) begin
                    next_tkState = TK_IDLE;
                end
            end
        endcase
        // An interrupted byte is not counted, so the next transfer resumes there
        if (!talkActive && tkState != TK_IDLE) begin
            next_tkState = TK_IDLE; // see R10
            next_dioOe = 1'b0;
            next_davOe = 1'b0;
            next_eoiOe = 1'b0;
        end
        // A new front-panel change wins over a clear in the same cycle
        if (remoteSel != remotePrev) begin
            next_srqPend = 1'b1; // see R3
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tkState <= TK_IDLE;
            monPtr <= `RP_HDR_SLOT;
            dioOutN <= '1;
            dioOe <= 1'b0;
            davOe <= 1'b0;
            eoiOe <= 1'b0;
            srqPend <= 1'b0;
            remotePrev <= 1'b0;
            srqOe <= 1'b0;
            davOutN <= 1'b0;
            eoiOutN <= 1'b0;
            srqOutN <= 1'b0;
        end else if (clkEn) begin
            tkState <= next_tkState;
            monPtr <= next_monPtr;
            dioOutN <= next_dioOutN;
            dioOe <= next_dioOe;
            davOe <= next_davOe;
            eoiOe <= next_eoiOe;
            srqPend <= next_srqPend;
            remotePrev <= remoteSel;
            srqOe <= next_srqPend;
        end
    end

endmodule : remote_param_port

/* core/word_buffer.sv */
`timescale 1ns/10ps
module word_buffer #(
    parameter int DEPTH = 2
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Streams
    word_stream_if.sink fill,
    word_stream_if.source drain
);
    import remote_port_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2) begin : g_check
            $error("word_buffer needs at least two entries");
        end
    endgenerate

    bus_word_type mem [DEPTH];
    logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign fill.ready = (count != (AW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.word = mem[rdPtr];

    always_comb begin
        push = fill.valid && fill.ready;
        pop = drain.valid && drain.ready;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (push) begin
            next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(wrPtr + 1'b1);
        end
        if (pop) begin
            next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(rdPtr + 1'b1);
        end
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (clkEn) begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage has no reset: an entry is only read after it was written
    always_ff @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr] <= fill.word;
        end
    end

endmodule : word_buffer

/* pkg/remote_port_consts.svh */
`ifndef REMOTE_PORT_CONSTS_SVH
`define REMOTE_PORT_CONSTS_SVH

// ----------------------------------------
// Parameter register map
// ----------------------------------------
`define RP_NUM_REGS 8
`define RP_REG_RESET 8'h00
`define RP_REG_MODE 3'h1
`define RP_REG_FREQ_HI 3'h2
`define RP_REG_FREQ_MID 3'h3
`define RP_REG_FREQ_LO 3'h4
`define RP_REG_BW_DET 3'h5
`define RP_REG_RF_GAIN 3'h7

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define RP_REMOTE_BIT 7
`define RP_SIGN_BIT 4
`define RP_GAIN_HI 3
`define RP_GAIN_LO 2
`define RP_TENS_HI 1
`define RP_BW_HI 7
`define RP_BW_LO 5
`define RP_DET_HI 4
`define RP_DET_AM 5'h1D
`define RP_HDR_MARK 2'h3
`define RP_HDR_GUARD_BIT 6

// ----------------------------------------
// Bus addressing and monitor sequence
// ----------------------------------------
`define RP_LISTEN_GRP 3'h1
`define RP_TALK_GRP 3'h2
`define RP_UNLISTEN 8'h3F
`define RP_UNTALK 8'h5F
`define RP_HDR_SLOT 4'h0
`define RP_LAST_SLOT 4'h8
`define RP_SLOT_STEP 4'h1

// ----------------------------------------
// Pin synchroniser layout
// ----------------------------------------
`define RP_PIN_W 16
`define RP_PIN_IDLE 16'h7FFF
`define RP_PIN_DAV 8
`define RP_PIN_NRFD 9
`define RP_PIN_NDAC 10
`define RP_PIN_ATN 11
`define RP_PIN_REN 12
`define RP_PIN_IFC 13
`define RP_PIN_EOI 14
`define RP_PIN_REMOTE 15
`define RP_BUF_DEPTH 2

`endif

/* pkg/remote_port_pkg.sv */
package remote_port_pkg;

    typedef logic [7:0] byte_type;

    typedef struct packed {
        logic eoi;
        logic cmd;
        byte_type value;
    } bus_word_type;

    typedef enum logic [1:0] {
        AC_IDLE = 2'b00,
        AC_READY = 2'b01,
        AC_TAKEN = 2'b10
    } accept_state_type;

    typedef enum logic [1:0] {
        PS_ADDR = 2'b00,
        PS_DATA = 2'b01,
        PS_APPLY = 2'b10
    } parse_state_type;

    typedef enum logic [1:0] {
        TK_IDLE = 2'b00,
        TK_SETUP = 2'b01,
        TK_VALID = 2'b10,
        TK_RELEASE = 2'b11
    } talk_state_type;

endpackage : remote_port_pkg

/* pkg/word_stream_if.sv */
`timescale 1ns/10ps
interface word_stream_if;
    import remote_port_pkg::*;
    bus_word_type word;
    logic valid;
    logic ready;
    modport source (output word, output valid, input ready);
    modport sink (input word, input valid, output ready);
endinterface : word_stream_if

/* tb/bus_controller_model.sv */
`timescale 1ns/10ps
module bus_controller_model (
    // Clock
    input wire logic clk,
    // Device drive
    input wire logic [7:0] dioOutN,
    input wire logic dioOe,
    input wire logic davOe,
    input wire logic nrfdOe,
    input wire logic ndacOe,
    input wire logic eoiOe,
    // Resolved bus lines
    output wire logic [7:0] dioN,
    output wire logic davN,
    output wire logic nrfdN,
    output wire logic ndacN,
    output wire logic eoiN,
    output wire logic atnN,
    output wire logic renN,
    output wire logic ifcN
);
    logic [7:0] val = 8'h00;
    logic drv = 0, dav = 0, nrfd = 0, ndac = 0, eoi = 0, atn = 0, ren = 1, ifc = 0;
    int dly = 0;
    wire [2:0] hs = {davN, nrfdN, ndacN};
    // Released lines go to the pull-up level, not the last value
    assign dioN = (dioOe ? dioOutN : 8'hFF) & (drv ? ~val : 8'hFF);
    assign davN = !(davOe || dav);
    assign nrfdN = !(nrfdOe || nrfd);
    assign ndacN = !(ndacOe || ndac);
    assign eoiN = !(eoiOe || eoi);
    assign atnN = !atn;
    assign renN = !ren;
    assign ifcN = !ifc;
    task automatic wt(input int k, input logic lvl);
        for (int i = 0; i < 100 && hs[k] !== lvl; i++) @(negedge clk);
    endtask : wt
    task automatic send(input logic [7:0] b, input logic a, input logic e);
        atn = !a;
        repeat (8) @(negedge clk);
        nrfd = 0;
        ndac = 0;
        wt(0, 0);
        wt(1, 1);
        val = b;
        drv = 1;
        eoi = e;
        @(negedge clk);
        dav = 1;
        wt(0, 1);
        dav = 0;
        wt(0, 0);
        drv = 0;
        eoi = 0;
    endtask : send
    task automatic rcv(output logic [7:0] b, output logic e);
        atn = 0;
        ndac = 1;
        repeat (dly) @(negedge clk);
        nrfd = 0;
        wt(2, 0);
        b = ~dioN;
        e = !eoiN;
        nrfd = 1;
        ndac = 0;
        wt(2, 1);
        ndac = 1;
    endtask : rcv
endmodule : bus_controller_model

/* tb/remote_param_port_sva.sv */
`timescale 1ns/10ps
module remote_param_port_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched ports
    input wire logic [4:0] busAddress,
    input wire logic remoteButton,
    input wire remote_port_pkg::byte_type dioOutN,
    input wire logic dioOe,
    input wire logic nrfdInN,
    input wire logic ndacInN,
    input wire logic davOe,
    input wire logic nrfdOe,
    input wire logic ndacOe,
    input wire logic eoiOe,
    input wire logic srqOe,
    input wire logic renN,
    input wire logic remoteFlag,
    input wire logic beatOscSign,
    input wire logic [4:0] detectionMode,
    input wire logic paramUpdate
);
    import remote_port_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_remote_mirror: assert property ($rose(remoteButton) |-> ##[2:6] remoteFlag)
        else $error("remote flag missed the button");
    a_sign_am: assert property (detectionMode == 5'h1D |-> !beatOscSign)
        else $error("oscillator sign shown in AM");
    a_hdr_addr: assert property ($rose(davOe) && dioOutN < 8'h40 |-> dioOutN[4:0] == ~busAddress && !eoiOe)
        else $error("header byte malformed");
    a_srq_clear: assert property ($fell(srqOe) |-> $past(dioOe) && $past(dioOutN) < 8'h40)
        else $error("service request cleared without header");
    a_talker_role: assert property (dioOe |-> !nrfdOe && !ndacOe)
        else $error("acceptor active while talking");
    a_write_ren: assert property (paramUpdate |-> !renN)
        else $error("write applied without remote enable");
    a_dav_ready: assert property ($rose(davOe) |-> $past(nrfdInN) && dioOe)
        else $error("data valid before ready");
    a_dav_accept: assert property ($fell(davOe) && dioOe |-> $past(ndacInN))
        else $error("data valid dropped before accept");
    a_eoi_data: assert property (eoiOe |-> dioOe)
        else $error("end mark without data");
    c_header: cover property ($rose(davOe) && dioOutN < 8'h40);
    c_write: cover property (paramUpdate);
    c_last: cover property (eoiOe && davOe);
endmodule : remote_param_port_sva

bind remote_param_port remote_param_port_sva chk (.clk, .sys_rst, .busAddress, .remoteButton, .dioOutN,
    .dioOe, .nrfdInN, .ndacInN, .davOe, .nrfdOe, .ndacOe, .eoiOe, .srqOe, .renN, .remoteFlag,
    .beatOscSign, .detectionMode, .paramUpdate);

/* tb/remote_receiver_parameter_port_tb.sv */
`timescale 1ns/10ps
module remote_receiver_parameter_port_tb;
    import remote_port_pkg::*;
    localparam logic [4:0] ADDR = 5'h06;
    logic clk = 0, sys_rst = 1, btn = 0;
    wire byte_type dioN, dioOutN;
    wire dioOe, davOe, nrfdOe, ndacOe, eoiOe, srqOe, remoteFlag, beatOscSign, paramUpdate;
    wire davN, nrfdN, ndacN, eoiN, atnN, renN, ifcN;
    wire [1:0] gainMode, freqTens;
    wire [23:0] freqDigits;
    wire [2:0] bandwidthCode;
    wire [4:0] detectionMode;
    wire [7:0] rfGain;
    logic [7:0] ex [8] = '{default: 8'h00};
    logic [10:0] cmds [20] = '{11'h105, 11'h180, 11'h184, 11'h188, 11'h190, 11'h185, 11'h195, 11'h223,
        11'h345, 11'h467, 11'h500, 11'h521, 11'h542, 11'h56B, 11'h59C, 11'h51D, 11'h57D, 11'h009, 11'h642, 11'h7FF};
    int fail_count = 0, cmp_count = 0, nUpd = 0, ptr = 0;
    wire [45:0] ctrl = {remoteFlag, beatOscSign, gainMode, freqTens, freqDigits, bandwidthCode, detectionMode, rfGain};
    wire [45:0] want = {btn, ex[1][4] && ex[5][4:0] != 5'h1D, ex[1][3:0], ex[2], ex[3], ex[4], ex[5], ex[7]};
    always #12.5 clk = ~clk;
    always @(posedge clk) if (paramUpdate === 1'b1) nUpd++;
    remote_param_port DUT (.clk, .sys_rst, .clkEn(1'b1), .busAddress(ADDR), .remoteButton(btn),
        .dioInN(dioN), .dioOutN, .dioOe, .davInN(davN), .davOutN(), .davOe, .nrfdInN(nrfdN),
        .nrfdOutN(), .nrfdOe, .ndacInN(ndacN), .ndacOutN(), .ndacOe, .atnN, .renN, .ifcN,
        .eoiInN(eoiN), .eoiOutN(), .eoiOe, .srqOutN(), .srqOe, .remoteFlag, .beatOscSign,
        .gainMode, .freqTens, .freqDigits, .bandwidthCode, .detectionMode, .rfGain, .paramUpdate);
    bus_controller_model ctl (.clk, .dioOutN, .dioOe, .davOe, .nrfdOe, .ndacOe, .eoiOe,
        .dioN, .davN, .nrfdN, .ndacN, .eoiN, .atnN, .renN, .ifcN);
    // ----------------------------------------
    // Checking and scenarios
    // ----------------------------------------
    task automatic report_and_stop();
        $display("Counts: %0d mismatches, %0d comparisons", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, s, e);
        end
    endtask : check
    task automatic wr(input logic [2:0] r, input byte_type v, input logic ok, input logic e);
        int n0;
        n0 = nUpd;
        if (ok) ex[r] = v;
        ctl.send({5'h00, r}, 1'b1, 1'b0);
        ctl.send(v, 1'b1, e);
        for (int i = 0; i < 20 && nUpd == n0; i++) @(negedge clk);
        check(nUpd - n0, ok);
        check(ctrl, want);
    endtask : wr
    task automatic mon(input int n);
        byte_type b, v;
        logic e;
        ctl.send({3'h2, ADDR}, 1'b0, 1'b0);
        repeat (n) begin
            v = ptr == 0 ? {3'b110, ADDR} : (ptr == 2 ? {btn, ex[1][6:0]} : ex[ptr - 1]);
            if (ptr != 0 && v[7:6] == 2'b11) v[6] = 1'b0;
            ctl.rcv(b, e);
            check({e, b}, {ptr == 8, v});
            ptr = (ptr + 1) % 9;
        end
        ctl.send(8'h5F, 1'b0, 1'b0);
    endtask : mon
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        check({dioOe, davOe, nrfdOe, ndacOe, eoiOe, srqOe, dioOutN}, {6'b0, 8'hFF});
        check(ctrl, 46'h0);
        btn = 1;
        repeat (8) @(negedge clk);
        check({remoteFlag, srqOe}, 2'b11);
        ctl.send({3'h1, ADDR}, 1'b0, 1'b0);
        foreach (cmds[i]) wr(cmds[i][10:8], cmds[i][7:0], 1'b1, i == 19);
        ctl.ren = 0;
        wr(3'h7, 8'h12, 1'b0, 1'b0);
        ctl.ren = 1;
        ctl.send(8'h3F, 1'b0, 1'b0);
        wr(3'h7, 8'h34, 1'b0, 1'b0);
        ctl.send({3'h1, ADDR}, 1'b0, 1'b0);
        ctl.ifc = 1;
        repeat (8) @(negedge clk);
        ctl.ifc = 0;
        wr(3'h7, 8'h56, 1'b0, 1'b0);
        check(srqOe, 1'b1);
        ctl.dly = 3;
        mon(9);
        check(srqOe, 1'b0);
        ctl.dly = 0;
        mon(3);
        mon(2);
        report_and_stop();
    end
endmodule : remote_receiver_parameter_port_tb
